/* rtl/irig_b_defines.svh */
// How it works
// - One full frame every second, restarted each second.
// - One hundred 10 ms element slots per frame.
// - Position identifier once in every ten slots.
// - Double position identifier marks the next on-time.
// - Every element starts high at its slot start.
// - Marker, zero or uncoded element lasts 2 ms.
// - Binary one element lasts 5 ms.
// - Position identifier element lasts 8 ms.
// - BCD seconds, minutes, hours, day of year, yearly wrap.
// - BCD from slot 1: 7, 7, 6, 10 coded elements.
// - Marker between digits; least significant first.
// - 17-bit binary seconds since midnight, daily wrap.
// - Binary seconds from slot 80, identifier after ninth.
// - Control field fills slots 50 to 78.
// - Slot 55 is one while radio synchronized.
// - Slots 60 to 63 carry year units, LSB first.
// - Slots 65 to 68 carry year tens, LSB first.
// - Unused control slots are sent as zero.
// - Signature control silences output while sync lost.
// - Amplitude form keys a 1 kHz carrier.
// - Pulse form 10 ms, amplitude form 1 ms resolution.
`ifndef IRIG_B_DEFINES_SVH
`define IRIG_B_DEFINES_SVH

`define IRIG_CLK_PERIOD_NS  10
`define IRIG_MS_TIME_NS     1000000
`define IRIG_SLOTS          7'h64
`define IRIG_MS_PER_SLOT    4'ha
`define IRIG_WIDTH_ZERO_MS  4'h2
`define IRIG_WIDTH_ONE_MS   4'h5
`define IRIG_WIDTH_PID_MS   4'h8
`define IRIG_POS_SYNC       55
`define IRIG_POS_YEAR_UNITS 60
`define IRIG_POS_YEAR_TENS  65
`define IRIG_POS_SBS_LOW    80
`define IRIG_POS_SBS_HIGH   90

`define IRIG_ADDR_CTRL      12'h000
`define IRIG_ADDR_TIME_SET  12'h004
`define IRIG_ADDR_DATE_SET  12'h008
`define IRIG_ADDR_STATUS    12'h00c
`define IRIG_ADDR_TIME_NOW  12'h010
`define IRIG_ADDR_DATE_NOW  12'h014

`define IRIG_CTRL_RUN       0
`define IRIG_CTRL_SIG_PWC   1
`define IRIG_CTRL_SIG_AM    2
`define IRIG_CTRL_RESET     3'h0
`define IRIG_DAY_RESET      9'h001

`endif

/* rtl/irig_b_pkg.sv */
package irig_b_pkg;

  typedef struct packed {
    logic [6:0] year;
    logic [8:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } tod_t;

  typedef struct packed {
    logic [99:0] one_bits;
    logic [99:0] pid_bits;
  } frame_t;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_DONE = 2'b10
  } apb_state_t;

endpackage

/* rtl/irig_b_time_code_generator.sv */
`timescale 1ns/1ps
`include "irig_b_defines.svh"

module irig_b_time_code_generator #(
  parameter int MS_CYCLES = `IRIG_MS_TIME_NS / `IRIG_CLK_PERIOD_NS
) (
  input  wire logic        I_CLK,
  input  wire logic        I_SRST,
  input  wire logic        I_SYNC_LOCKED,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             O_PWC,
  output logic             O_AM_CARRIER,
  output logic             O_AM_MARK,
  output logic             O_FRAME_START
);

  // Converts a value below 1000 to three packed BCD digits.
  function automatic logic [11:0] to_bcd(input logic [9:0] v);
    logic [9:0] u;
    logic [9:0] t;
    logic [9:0] h;
    u = v % 10'd10;
    t = (v / 10'd10) % 10'd10;
    h = v / 10'd100;
    return {h[3:0], t[3:0], u[3:0]};
  endfunction

  // Advances the time of year by one second.
  function automatic irig_b_pkg::tod_t next_tod(input irig_b_pkg::tod_t t);
    irig_b_pkg::tod_t n;
    logic             leap;
    n = t;
    leap = (t.year[1:0] == 2'b00);
    if (t.second != 6'd59)
    begin
      n.second = t.second + 6'd1;
    end
    else
    begin
      n.second = 6'd0;
      if (t.minute != 6'd59)
      begin
        n.minute = t.minute + 6'd1;
      end
      else
      begin
        n.minute = 6'd0;
        if (t.hour != 5'd23)
        begin
          n.hour = t.hour + 5'd1;
        end
        else
        begin
          n.hour = 5'd0;
          if (t.day < (leap ? 9'd366 : 9'd365))
          begin
            n.day = t.day + 9'd1;
          end
          else
          begin
            n.day = 9'd1;
            n.year = (t.year == 7'd99) ? 7'd0 : t.year + 7'd1;
          end
        end
      end
    end
    return n;
  endfunction

  // Builds the element pattern of one frame from the time it stands for.
  function automatic irig_b_pkg::frame_t encode(input irig_b_pkg::tod_t t,
                                                input logic synced);
    irig_b_pkg::frame_t f;
    logic [11:0]        s_bcd;
    logic [11:0]        m_bcd;
    logic [11:0]        h_bcd;
    logic [11:0]        d_bcd;
    logic [11:0]        y_bcd;
    logic [16:0]        sbs;
    logic               year_units_weight_one;
    logic               year_units_weight_two;
    logic               year_units_weight_four;
    logic               year_units_weight_eight;
    logic               year_tens_weight_ten;
    logic               year_tens_weight_twenty;
    logic               year_tens_weight_forty;
    logic               year_tens_weight_eighty;
    f = '0;
    s_bcd = to_bcd({4'h0, t.second});
    m_bcd = to_bcd({4'h0, t.minute});
    h_bcd = to_bcd({5'h00, t.hour});
    d_bcd = to_bcd({1'b0, t.day});
    y_bcd = to_bcd({3'h0, t.year});
    sbs = 17'(t.hour) * 17'd3600 + 17'(t.minute) * 17'd60 + 17'(t.second);
    f.pid_bits[0] = 1'b1;
    for (int k = 9; k < 100; k += 10)
    begin
      f.pid_bits[k] = 1'b1;
    end
    // Slots 5, 14, 24 and 34 are the index markers between digits.
    f.one_bits[4:1] = s_bcd[3:0];
    f.one_bits[8:6] = s_bcd[6:4];
    f.one_bits[13:10] = m_bcd[3:0];
    f.one_bits[17:15] = m_bcd[6:4];
    f.one_bits[23:20] = h_bcd[3:0];
    f.one_bits[26:25] = h_bcd[5:4];
    f.one_bits[33:30] = d_bcd[3:0];
    f.one_bits[38:35] = d_bcd[7:4];
    f.one_bits[41:40] = d_bcd[9:8];
    // Control slots 50 to 78 stay zero apart from status and year.
    f.one_bits[`IRIG_POS_SYNC] = synced;
    // Year digits go out as separate weighted bits, lowest weight first.
    year_units_weight_one = y_bcd[0];
    year_units_weight_two = y_bcd[1];
    year_units_weight_four = y_bcd[2];
    year_units_weight_eight = y_bcd[3];
    year_tens_weight_ten = y_bcd[4];
    year_tens_weight_twenty = y_bcd[5];
    year_tens_weight_forty = y_bcd[6];
    year_tens_weight_eighty = y_bcd[7];
    f.one_bits[`IRIG_POS_YEAR_UNITS] = year_units_weight_one;
    f.one_bits[`IRIG_POS_YEAR_UNITS + 1] = year_units_weight_two;
    f.one_bits[`IRIG_POS_YEAR_UNITS + 2] = year_units_weight_four;
    f.one_bits[`IRIG_POS_YEAR_UNITS + 3] = year_units_weight_eight;
    f.one_bits[`IRIG_POS_YEAR_TENS] = year_tens_weight_ten;
    f.one_bits[`IRIG_POS_YEAR_TENS + 1] = year_tens_weight_twenty;
    f.one_bits[`IRIG_POS_YEAR_TENS + 2] = year_tens_weight_forty;
    f.one_bits[`IRIG_POS_YEAR_TENS + 3] = year_tens_weight_eighty;
    f.one_bits[`IRIG_POS_SBS_LOW +: 9] = sbs[8:0];
    f.one_bits[`IRIG_POS_SBS_HIGH +: 8] = sbs[16:9];
    return f;
  endfunction

  logic [16:0]            cyc_q;
  logic [16:0]            cyc_d;
  logic [3:0]             ms_q;
  logic [3:0]             ms_d;
  logic [6:0]             slot_q;
  logic [6:0]             slot_d;
  logic [2:0]             ctrl_q;
  logic [2:0]             ctrl_d;
  logic                   run_q;
  irig_b_pkg::tod_t       tod_q;
  irig_b_pkg::tod_t       tod_d;
  irig_b_pkg::tod_t       set_q;
  irig_b_pkg::tod_t       set_d;
  logic                   load_q;
  logic                   load_d;
  irig_b_pkg::frame_t     frame_q;
  irig_b_pkg::frame_t     frame_d;
  irig_b_pkg::apb_state_t apb_q;
  irig_b_pkg::apb_state_t apb_d;
  logic [31:0]            rdata_d;
  logic                   slverr_d;

  wire logic              ms_tick;
  wire logic              slot_end;
  wire logic              frame_end;
  wire logic              frame_start;
  wire irig_b_pkg::tod_t  tod_next;
  wire logic [3:0]        width_ms;
  wire logic              pulse_on;
  wire logic              carrier_on;
  wire logic              kill_pwc;
  wire logic              kill_am;
  wire logic              apb_access;
  wire logic              apb_write;
  wire logic              sel_ctrl;
  wire logic              sel_time_set;
  wire logic              sel_date_set;
  wire logic              sel_status;
  wire logic              sel_time_now;
  wire logic              sel_date_now;
  wire logic              sel_any;

  // Millisecond, slot and frame timing.
  assign ms_tick = (cyc_q == 17'(MS_CYCLES - 1));
  assign slot_end = ms_tick && (ms_q == `IRIG_MS_PER_SLOT - 4'h1);
  assign frame_end = slot_end && (slot_q == `IRIG_SLOTS - 7'h1);
  assign frame_start = frame_end || (ctrl_q[`IRIG_CTRL_RUN] && !run_q);

  assign cyc_d = (!run_q || ms_tick) ? 17'h00000 : cyc_q + 17'h00001;
  assign ms_d = (!run_q || slot_end) ? 4'h0 : (ms_tick ? ms_q + 4'h1 : ms_q);
  assign slot_d = (!run_q || frame_end) ? 7'h00 : (slot_end ? slot_q + 7'h01 : slot_q);

  // Time keeping: a software load wins over the one-second step.
  assign tod_next = load_q ? set_q : next_tod(tod_q);
  assign tod_d = (frame_end || (!run_q && load_q)) ? tod_next : tod_q;

  // The sync status bit is taken once, as the frame is built.
  // The new frame is latched at its own on-time edge from the time it carries.
  assign frame_d = frame_start ? encode(frame_end ? tod_next : tod_q, I_SYNC_LOCKED)
                               : frame_q;

  // Pulse width chosen per slot, measured from the slot's leading edge.
  assign width_ms = frame_q.pid_bits[slot_q] ? `IRIG_WIDTH_PID_MS :
                    frame_q.one_bits[slot_q] ? `IRIG_WIDTH_ONE_MS :
                                               `IRIG_WIDTH_ZERO_MS;
  assign pulse_on = run_q && (ms_q < width_ms);
  assign carrier_on = run_q && (cyc_q < 17'(MS_CYCLES / 2));
  // Muting keys only the mark; the carrier runs on so receivers keep lock.
  assign kill_pwc = ctrl_q[`IRIG_CTRL_SIG_PWC] && !I_SYNC_LOCKED;
  assign kill_am = ctrl_q[`IRIG_CTRL_SIG_AM] && !I_SYNC_LOCKED;

  // Register bus decode; one wait state before every answer.
  assign apb_access = PSEL && PENABLE && (apb_q == irig_b_pkg::APB_DONE);
  assign apb_write = apb_access && PWRITE && !slverr_d;
  assign sel_ctrl = (PADDR == `IRIG_ADDR_CTRL);
  assign sel_time_set = (PADDR == `IRIG_ADDR_TIME_SET);
  assign sel_date_set = (PADDR == `IRIG_ADDR_DATE_SET);
  assign sel_status = (PADDR == `IRIG_ADDR_STATUS);
  assign sel_time_now = (PADDR == `IRIG_ADDR_TIME_NOW);
  assign sel_date_now = (PADDR == `IRIG_ADDR_DATE_NOW);
  assign sel_any = sel_ctrl || sel_time_set || sel_date_set || sel_status ||
                   sel_time_now || sel_date_now;

  // The first access cycle arms the answer and the next one carries it.
  always_comb
  begin
    apb_d = irig_b_pkg::APB_IDLE;
    case (apb_q)
      irig_b_pkg::APB_IDLE:
      begin
        if (PSEL && PENABLE)
        begin
          apb_d = irig_b_pkg::APB_DONE;
        end
      end
      irig_b_pkg::APB_DONE:
      begin
        apb_d = irig_b_pkg::APB_IDLE;
      end
      default:
      begin
        apb_d = irig_b_pkg::APB_IDLE;
      end
    endcase
  end

  assign ctrl_d = (apb_write && sel_ctrl) ? PWDATA[2:0] : ctrl_q;

  always_comb
  begin
    set_d = set_q;
    if (apb_write && sel_time_set)
    begin
      set_d.second = PWDATA[5:0];
      set_d.minute = PWDATA[13:8];
      set_d.hour = PWDATA[20:16];
    end
    else if (apb_write && sel_date_set)
    begin
      set_d.day = PWDATA[8:0];
      set_d.year = PWDATA[22:16];
    end
  end

  // A fresh write re-arms the load in the same cycle that the old one is used.
  assign load_d = (apb_write && (sel_time_set || sel_date_set)) ||
                  (load_q && !frame_end && run_q);

  always_comb
  begin
    rdata_d = 32'h00000000;
    slverr_d = 1'b0;
    if (sel_ctrl)
    begin
      rdata_d = {29'h00000000, ctrl_q};
    end
    else if (sel_time_set)
    begin
      rdata_d = {11'h000, set_q.hour, 2'h0, set_q.minute, 2'h0, set_q.second};
    end
    else if (sel_date_set)
    begin
      rdata_d = {9'h000, set_q.year, 7'h00, set_q.day};
    end
    else if (sel_status)
    begin
      rdata_d = {17'h00000, slot_q, 5'h00, run_q, load_q, I_SYNC_LOCKED};
    end
    else if (sel_time_now)
    begin
      rdata_d = {11'h000, tod_q.hour, 2'h0, tod_q.minute, 2'h0, tod_q.second};
    end
    else if (sel_date_now)
    begin
      rdata_d = {9'h000, tod_q.year, 7'h00, tod_q.day};
    end
    else
    begin
      slverr_d = 1'b1;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      cyc_q <= 17'h00000;
      ms_q <= 4'h0;
      slot_q <= 7'h00;
      ctrl_q <= `IRIG_CTRL_RESET;
      run_q <= 1'b0;
      tod_q <= '{year: 7'h00, day: `IRIG_DAY_RESET, hour: 5'h00, minute: 6'h00,
                 second: 6'h00};
      set_q <= '{year: 7'h00, day: `IRIG_DAY_RESET, hour: 5'h00, minute: 6'h00,
                 second: 6'h00};
      load_q <= 1'b0;
      frame_q <= '0;
      apb_q <= irig_b_pkg::APB_IDLE;
    end
    else
    begin
      cyc_q <= cyc_d;
      ms_q <= ms_d;
      slot_q <= slot_d;
      ctrl_q <= ctrl_d;
      run_q <= ctrl_q[`IRIG_CTRL_RUN];
      tod_q <= tod_d;
      set_q <= set_d;
      load_q <= load_d;
      frame_q <= frame_d;
      apb_q <= apb_d;
    end
  end

  // Bus answer registers.
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= (apb_d == irig_b_pkg::APB_DONE);
      PSLVERR <= (apb_d == irig_b_pkg::APB_DONE) && slverr_d;
      PRDATA <= (apb_d == irig_b_pkg::APB_DONE && !PWRITE) ? rdata_d : 32'h00000000;
    end
  end

  // Code outputs, one clock behind the timing counters.
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      O_PWC <= 1'b0;
      O_AM_CARRIER <= 1'b0;
      O_AM_MARK <= 1'b0;
      O_FRAME_START <= 1'b0;
    end
    else
    begin
      O_PWC <= pulse_on && !kill_pwc;
      O_AM_CARRIER <= carrier_on;
      O_AM_MARK <= pulse_on && !kill_am;
      O_FRAME_START <= run_q && (ms_q == 4'h0) && (cyc_q == 17'h00000) &&
                       (slot_q == 7'h00);
    end
  end

endmodule

/* tb/irig_b_assertions.sv */
`timescale 1ns/1ps
module irig_b_assertions #(
  parameter int MS_CYCLES = 10
) (
  input wire logic        I_CLK,
  input wire logic        I_SRST,
  input wire logic        I_SYNC_LOCKED,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        O_PWC,
  input wire logic        O_AM_CARRIER,
  input wire logic        O_AM_MARK,
  input wire logic        O_FRAME_START
);
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (I_SRST);
  localparam int SLOT = 10 * MS_CYCLES;
  int         hi_q;
  int         car_q;
  int         per_q;
  int         last_q;
  logic       seen_q;
  logic       pwc_q;
  logic [2:0] ctrl_q;
  wire        rise = O_PWC && !pwc_q;
  wire        ctrl_wr = PSEL && PENABLE && PREADY && PWRITE && (PADDR == 12'h000);
  // A muted or stopped stretch clears seen_q once per_q passes SLOT, so the late rise after it goes unchecked.
  always_ff @(posedge I_CLK)
  begin
    pwc_q  <= O_PWC;
    hi_q   <= O_PWC ? hi_q + 1 : 0;
    car_q  <= O_AM_CARRIER ? car_q + 1 : 0;
    per_q  <= rise ? 1 : per_q + 1;
    seen_q <= I_SRST ? 1'b0 : (rise ? 1'b1 : ((per_q > SLOT) ? 1'b0 : seen_q));
    last_q <= (pwc_q && !O_PWC) ? hi_q : last_q;
    ctrl_q <= I_SRST ? 3'h0 : (ctrl_wr ? PWDATA[2:0] : ctrl_q);
  end
  sequence access_s;
    PSEL && $rose(PENABLE);
  endsequence
  sequence pwc_muted_s;
    (ctrl_q[1] && !I_SYNC_LOCKED) [*2];
  endsequence
  sequence am_muted_s;
    (ctrl_q[2] && !I_SYNC_LOCKED) [*2];
  endsequence
  width_legal_a: assert property ($fell(O_PWC) && !ctrl_q[1] |->
    hi_q inside {2 * MS_CYCLES, 5 * MS_CYCLES, 8 * MS_CYCLES}) else $error("bad pulse width");
  slot_period_a: assert property (rise && seen_q |-> per_q == SLOT)
    else $error("slot period wrong");
  frame_edge_a: assert property (O_FRAME_START |-> rise)
    else $error("frame start off the leading edge");
  ref_marker_a: assert property (O_FRAME_START && seen_q |-> last_q == 8 * MS_CYCLES)
    else $error("no identifier before frame");
  carrier_half_a: assert property ($fell(O_AM_CARRIER) |-> car_q == MS_CYCLES / 2)
    else $error("carrier half period wrong");
  pwc_mute_a: assert property (pwc_muted_s |-> !O_PWC)
    else $error("pulse output not muted");
  am_mute_a: assert property (am_muted_s |-> !O_AM_MARK)
    else $error("amplitude mark not muted");
  apb_ready_a: assert property (access_s |=> PREADY ##1 !PREADY)
    else $error("ready not one cycle in second access cycle");
endmodule

bind irig_b_time_code_generator irig_b_assertions #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .I_CLK(I_CLK), .I_SRST(I_SRST), .I_SYNC_LOCKED(I_SYNC_LOCKED), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .O_PWC(O_PWC), .O_AM_CARRIER(O_AM_CARRIER),
  .O_AM_MARK(O_AM_MARK), .O_FRAME_START(O_FRAME_START));

/* tb/irig_b_decoder_model.sv */
`timescale 1ns/1ps
module irig_b_decoder_model #(
  parameter int MS_CYCLES = 10
) (
  input  wire logic        i_clk,
  input  wire logic        i_pwc,
  input  wire logic        i_start,
  output logic      [99:0] o_ones,
  output logic      [99:0] o_pids
);
  int   hi_q = 0;
  int   idx_q = 0;
  logic pwc_q = 1'b0;
  // Each pulse is classed by its width when it falls; the slot index restarts on frame start.
  always_ff @(posedge i_clk)
  begin
    pwc_q <= i_pwc;
    hi_q  <= i_pwc ? hi_q + 1 : 0;
    if (i_start)
    begin
      idx_q <= 0;
    end
    else if (pwc_q && !i_pwc && idx_q < 100)
    begin
      o_ones[idx_q] <= (hi_q == 5 * MS_CYCLES);
      o_pids[idx_q] <= (hi_q == 8 * MS_CYCLES);
      idx_q         <= idx_q + 1;
    end
  end
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  localparam int MS = 10;
  logic        clk, srst, locked, psel, penable, pwrite, pready, pslverr;
  logic        pwc, car, mark, fst, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [99:0] ones, pids, pid_map;
  int          mismatches, comparisons;
  irig_b_time_code_generator #(.MS_CYCLES(MS)) DUT (.I_CLK(clk), .I_SRST(srst),
    .I_SYNC_LOCKED(locked), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .O_PWC(pwc),
    .O_AM_CARRIER(car), .O_AM_MARK(mark), .O_FRAME_START(fst));
  irig_b_decoder_model #(.MS_CYCLES(MS)) u_dec (.i_clk(clk), .i_pwc(pwc), .i_start(fst),
    .o_ones(ones), .o_pids(pids));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string name, input logic [99:0] seen, input logic [99:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20)
    begin
      mismatches++;
      end_of_test;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_start;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (fst !== 1'b1 && n < 12000);
    if (n >= 12000)
    begin
      mismatches++;
      end_of_test;
    end
  endtask
  function automatic logic [99:0] exp_ones(input int s, mi, h, dy, yr, sy);
    logic [99:0] f;
    logic [16:0] sbs;
    f = '0;
    sbs = 17'(s + 60 * mi + 3600 * h);
    f[4:1] = 4'(s % 10);
    f[8:6] = 3'(s / 10);
    f[13:10] = 4'(mi % 10);
    f[17:15] = 3'(mi / 10);
    f[23:20] = 4'(h % 10);
    f[26:25] = 2'(h / 10);
    f[33:30] = 4'(dy % 10);
    f[38:35] = 4'((dy / 10) % 10);
    f[41:40] = 2'(dy / 100);
    f[55] = 1'(sy);
    f[63:60] = 4'(yr % 10);
    f[68:65] = 4'(yr / 10);
    f[88:80] = sbs[8:0];
    f[97:90] = sbs[16:9];
    return f;
  endfunction
  task automatic test_frames;
    apb(1'b1, 12'h004, {11'h0, 5'h17, 2'h0, 6'h3b, 2'h0, 6'h3b});
    apb(1'b1, 12'h008, {9'h0, 7'h57, 7'h0, 9'h0c8});
    apb(1'b1, 12'h000, 32'h1);
    wait_start;
    locked <= 1'b0;
    wait_start;
    check("frame0 ones", ones, exp_ones(59, 59, 23, 200, 87, 1));
    check("frame0 pids", pids, pid_map);
    apb(1'b0, 12'h014, 32'h0);
    check("date now", 100'(rd), 100'h005700c9);
    wait_start;
    check("frame1 ones", ones, exp_ones(0, 0, 0, 201, 87, 0));
    check("frame1 pids", pids, pid_map);
  endtask
  task automatic test_unmapped;
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped err", 100'(err), 100'h1);
    check("unmapped data", 100'(rd), 100'h0);
  endtask
  task automatic test_mute;
    int hi;
    int rises;
    logic prev;
    hi = 0;
    rises = 0;
    prev = car;
    apb(1'b1, 12'h000, 32'h7);
    repeat (2)
      @(posedge clk);
    prev = car;
    repeat (20 * MS)
    begin
      @(posedge clk);
      hi += (pwc | mark) ? 1 : 0;
      rises += (car && !prev) ? 1 : 0;
      prev = car;
    end
    check("muted outputs", 100'(hi), 100'h0);
    check("carrier runs", 100'(rises), 100'h14);
  endtask
  initial
  begin
    srst = 1'b1;
    locked = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mismatches = 0;
    comparisons = 0;
    pid_map = 100'h1;
    for (int i = 0; i < 10; i++)
      pid_map[i * 10 + 9] = 1'b1;
    repeat (4)
      @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    test_frames;
    test_unmapped;
    test_mute;
    end_of_test;
  end
endmodule
